// [aur_regs.sv]
`timescale 1ns/1ps
module aur_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic [4:0] phy_addr,
  input wire logic role_strap,
  input wire logic page_stored,
  input wire logic base_page_stored,
  input wire logic partner_fault,
  input wire logic negotiation_finished,
  input wire logic link_ok,
  input wire logic local_acknowledge,
  input wire logic restart_begun,
  output logic negotiation_enable,
  output logic negotiation_restart,
  output logic local_next_page_request,
  output logic local_fault_advertised,
  output logic role_forced_select,
  output logic [1:0] pause_capability,
  output logic role_master_select,
  output logic ten_t1l_ability
);
  logic [7:0] pins_s;
  logic mdc_s;
  logic mdio_s;
  logic [4:0] phy_addr_s;
  logic strap_s;
  logic mdc_d_ff;
  logic rise;
  aur_pkg::aur_frame_e state_ff;
  logic [5:0] ones_ff;
  logic [4:0] cnt_ff;
  logic [15:0] sh_ff;
  logic [13:0] hdr;
  logic [15:0] word;
  logic hdr_hit;
  logic hdr_end;
  logic frame_end;
  logic [1:0] op_ff;
  logic hit_ff;
  logic [15:0] addr_ff;
  logic [15:0] tx_ff;
  logic rd_go;
  logic status_rd;
  logic wr_go;
  logic page_q;
  logic fault_q;
  logic link_q;
  logic base_valid_ff;
  logic done_live;
  logic [1:0] strap_cnt_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Pins are asynchronous to mclk; mdc must stay well below mclk / 4
  aur_sync #(.WIDTH(8)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({role_strap, phy_addr, mdc, mdio_in}),
    .sync_out(pins_s)
  );
  assign strap_s = pins_s[7];
  assign phy_addr_s = pins_s[6:2];
  assign mdc_s = pins_s[1];
  assign mdio_s = pins_s[0];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mdc_d_ff <= 1'b0;
    end else begin
      mdc_d_ff <= mdc_s;
    end
  end
  assign rise = mdc_s & ~mdc_d_ff;

  // Header bits: [13:12] start, [11:10] op, [9:5] port, [4:0] device
  assign hdr = {sh_ff[12:0], mdio_s};
  assign word = {sh_ff[14:0], mdio_s};
  assign hdr_hit = (hdr[13:12] == 2'h0) && (hdr[9:5] == phy_addr_s) &&
                   (hdr[4:0] == aur_pkg::MMD_AN);
  assign hdr_end = rise && (state_ff == aur_pkg::AUR_FR_HDR) &&
                   (cnt_ff == aur_pkg::CNT_HDR_LAST);
  assign frame_end = rise && (state_ff == aur_pkg::AUR_FR_DATA) &&
                     (cnt_ff == aur_pkg::CNT_DATA_LAST);
  assign rd_go = hdr_end && hdr_hit && hdr[11];
  assign status_rd = rd_go && (addr_ff == aur_pkg::REG_STATUS);
  assign wr_go = frame_end && hit_ff && (op_ff == aur_pkg::OP_WRITE);

  // Frame sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= aur_pkg::AUR_FR_PRE;
      ones_ff <= 6'h00;
      cnt_ff <= 5'h00;
      sh_ff <= 16'h0000;
      op_ff <= 2'h0;
      hit_ff <= 1'b0;
    end else if (rise) begin
      unique case (state_ff)
        aur_pkg::AUR_FR_PRE: begin
          if (mdio_s) begin
            if (ones_ff != aur_pkg::PREAMBLE_LEN) begin
              ones_ff <= ones_ff + 6'h01;
            end
          end else if (ones_ff == aur_pkg::PREAMBLE_LEN) begin
            state_ff <= aur_pkg::AUR_FR_HDR;
            cnt_ff <= 5'h01;
            sh_ff <= 16'h0000;
          end else begin
            ones_ff <= 6'h00;
          end
        end
        aur_pkg::AUR_FR_HDR: begin
          sh_ff <= word;
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == aur_pkg::CNT_HDR_LAST) begin
            op_ff <= hdr[11:10];
            hit_ff <= hdr_hit;
            if (hdr[13:12] == 2'h0) begin
              state_ff <= aur_pkg::AUR_FR_TURN;
            end else begin
              // Not a clause 45 frame: hunt for a new preamble
              state_ff <= aur_pkg::AUR_FR_PRE;
              ones_ff <= 6'h00;
            end
          end
        end
        aur_pkg::AUR_FR_TURN: begin
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == aur_pkg::CNT_TA_LAST) begin
            state_ff <= aur_pkg::AUR_FR_DATA;
          end
        end
        aur_pkg::AUR_FR_DATA: begin
          sh_ff <= word;
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == aur_pkg::CNT_DATA_LAST) begin
            state_ff <= aur_pkg::AUR_FR_PRE;
            ones_ff <= 6'h00;
          end
        end
      endcase
    end
  end

  // Address register; read-increment steps after the data phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_ff <= 16'h0000;
    end else if (frame_end && hit_ff) begin
      if (op_ff == aur_pkg::OP_ADDR) begin
        addr_ff <= word;
      end else if (op_ff == aur_pkg::OP_READ_INC) begin
        addr_ff <= addr_ff + 16'h0001;
      end
    end
  end

  function automatic logic [15:0] read_word(
    input logic [15:0] a,
    input logic en,
    input logic rs,
    input logic pg,
    input logic dn,
    input logic fl,
    input logic lk
  );
    logic [15:0] r;
    r = 16'h0000;
    if (a == aur_pkg::REG_CTRL) begin
      r[aur_pkg::CTRL_EN_BIT] = en;
      r[aur_pkg::CTRL_RESTART_BIT] = rs;
    end else if (a == aur_pkg::REG_STATUS) begin
      r[aur_pkg::ST_PAGE_BIT] = pg;
      r[aur_pkg::ST_DONE_BIT] = dn;
      r[aur_pkg::ST_FAULT_BIT] = fl;
      r[aur_pkg::ST_ABLE_BIT] = 1'b1;
      r[aur_pkg::ST_LINK_BIT] = lk;
    end else if (a == aur_pkg::REG_ADV_L) begin
      r[aur_pkg::ADV_NP_BIT] = local_next_page_request;
      r[aur_pkg::ADV_ACK_BIT] = local_acknowledge;
      r[aur_pkg::ADV_RF_BIT] = local_fault_advertised;
      r[aur_pkg::ADV_FMS_BIT] = role_forced_select;
      r[aur_pkg::ADV_PAUSE_LSB+1:aur_pkg::ADV_PAUSE_LSB] = pause_capability;
      r[4:0] = aur_pkg::SELECTOR_VALUE;
    end else if (a == aur_pkg::REG_ADV_M) begin
      r[aur_pkg::ADV_M_B10L_BIT] = ten_t1l_ability;
      r[aur_pkg::ADV_M_MST_BIT] = role_master_select;
    end
    return r;
  endfunction

  // Read data is frozen at the end of the header, the same edge that
  // clears the latched status bits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_ff <= 16'h0000;
    end else if (rd_go) begin
      tx_ff <= read_word(addr_ff, negotiation_enable, negotiation_restart,
                         page_q, done_live, fault_q, link_q);
    end else if (rise && (state_ff != aur_pkg::AUR_FR_HDR) &&
                 (cnt_ff >= aur_pkg::CNT_TA_LAST)) begin
      tx_ff <= {tx_ff[14:0], 1'b0};
    end
  end

  // Pin driver: release for the first turnaround bit, 0 on the second,
  // then data MSB first; changes follow the mdc rising edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else if (rise && hit_ff && op_ff[1]) begin
      if ((state_ff == aur_pkg::AUR_FR_TURN) &&
          (cnt_ff == aur_pkg::CNT_TA_FIRST)) begin
        mdio_out <= 1'b0;
        mdio_oe_n <= 1'b0;
      end else if (frame_end) begin
        mdio_out <= 1'b1;
        mdio_oe_n <= 1'b1;
      end else if ((state_ff != aur_pkg::AUR_FR_PRE) &&
                   (state_ff != aur_pkg::AUR_FR_HDR) &&
                   (cnt_ff >= aur_pkg::CNT_TA_LAST)) begin
        mdio_out <= tx_ff[15];
      end
    end else if (rise && (state_ff == aur_pkg::AUR_FR_PRE)) begin
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
    end
  end

  // Control register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      negotiation_enable <= aur_pkg::CTRL_RESET[aur_pkg::CTRL_EN_BIT];
      negotiation_restart <= aur_pkg::CTRL_RESET[aur_pkg::CTRL_RESTART_BIT];
    end else begin
      if (wr_go && (addr_ff == aur_pkg::REG_CTRL)) begin
        negotiation_enable <= word[aur_pkg::CTRL_EN_BIT];
      end
      // A fresh request wins over the engine's acknowledge
      if (wr_go && (addr_ff == aur_pkg::REG_CTRL) &&
          word[aur_pkg::CTRL_RESTART_BIT]) begin
        negotiation_restart <= 1'b1;
      end else if (restart_begun) begin
        negotiation_restart <= 1'b0;
      end
    end
  end

  // Advertisement low word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      local_next_page_request <= aur_pkg::ADV_L_RESET[aur_pkg::ADV_NP_BIT];
      local_fault_advertised <= aur_pkg::ADV_L_RESET[aur_pkg::ADV_RF_BIT];
      role_forced_select <= aur_pkg::ADV_L_RESET[aur_pkg::ADV_FMS_BIT];
      pause_capability <= aur_pkg::ADV_L_RESET[11:10];
    end else if (wr_go && (addr_ff == aur_pkg::REG_ADV_L)) begin
      local_next_page_request <= word[aur_pkg::ADV_NP_BIT];
      local_fault_advertised <= word[aur_pkg::ADV_RF_BIT];
      role_forced_select <= word[aur_pkg::ADV_FMS_BIT];
      pause_capability <= word[11:10];
    end
  end

  // Next advertisement word; role bit takes its strap once pins settle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ten_t1l_ability <= aur_pkg::ADV_M_RESET[aur_pkg::ADV_M_B10L_BIT];
      role_master_select <= aur_pkg::ADV_M_RESET[aur_pkg::ADV_M_MST_BIT];
      strap_cnt_ff <= 2'h0;
    end else if (strap_cnt_ff != aur_pkg::STRAP_WAIT) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      role_master_select <= strap_s;
    end else if (wr_go && (addr_ff == aur_pkg::REG_ADV_M)) begin
      ten_t1l_ability <= word[aur_pkg::ADV_M_B10L_BIT];
      role_master_select <= word[aur_pkg::ADV_M_MST_BIT];
    end
  end

  // Status bits
  aur_latch_bit #(.LATCH_LOW(1'b0)) u_page (
    .mclk(mclk),
    .rst(rst),
    .cond(page_stored),
    .rd_clr(status_rd),
    .q(page_q)
  );
  aur_latch_bit #(.LATCH_LOW(1'b0)) u_fault (
    .mclk(mclk),
    .rst(rst),
    .cond(base_page_stored & partner_fault),
    .rd_clr(status_rd),
    .q(fault_q)
  );
  aur_latch_bit #(.LATCH_LOW(1'b1)) u_link (
    .mclk(mclk),
    .rst(rst),
    .cond(link_ok),
    .rd_clr(status_rd),
    .q(link_q)
  );

  // Partner base page is invalid again once a new negotiation starts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      base_valid_ff <= 1'b0;
    end else if (base_page_stored) begin
      base_valid_ff <= 1'b1;
    end else if (!negotiation_enable || restart_begun) begin
      base_valid_ff <= 1'b0;
    end
  end

  assign done_live = negotiation_finished & link_ok & base_valid_ff &
                     negotiation_enable;

  page_set_a: assert property (page_stored |=> page_q)
    else $error("page flag not set by stored codeword");
  page_clr_a: assert property (status_rd && !page_stored |=> !page_q)
    else $error("page flag not cleared by status read");
  done_dis_a: assert property (status_rd && !negotiation_enable
    |=> !tx_ff[aur_pkg::ST_DONE_BIT])
    else $error("done read as 1 while disabled");
  done_val_a: assert property (status_rd && !base_valid_ff
    |=> !tx_ff[aur_pkg::ST_DONE_BIT])
    else $error("done read as 1 without valid partner page");
  fault_hold_a: assert property (fault_q && !status_rd |=> fault_q)
    else $error("fault bit dropped before read");
  able_read_a: assert property (status_rd |=> tx_ff[15:7] == 9'h000
    && tx_ff[aur_pkg::ST_ABLE_BIT])
    else $error("ability bit not 1 on status read");
  link_low_a: assert property (!link_ok && !status_rd |=> !link_q)
    else $error("link bit not latched low");
  restart_hold_a: assert property (negotiation_restart
    && !restart_begun |=> negotiation_restart)
    else $error("restart cleared before it began");
  sel_read_a: assert property (rd_go && addr_ff == aur_pkg::REG_ADV_L
    |=> tx_ff[4:0] == aur_pkg::SELECTOR_VALUE)
    else $error("selector not 00001");
  np_write_a: assert property (wr_go && addr_ff == aur_pkg::REG_ADV_L
    |=> local_next_page_request == $past(word[aur_pkg::ADV_NP_BIT]))
    else $error("next page bit not written");
  release_end_a: assert property (frame_end |=> mdio_oe_n)
    else $error("pin still driven after read frame");

  status_rd_c: cover property (status_rd ##1 mdio_oe_n [*3]);
  adv_wr_c: cover property (wr_go && addr_ff == aur_pkg::REG_ADV_L);
  restart_c: cover property (negotiation_restart ##[1:20] restart_begun);
  done_c: cover property (done_live && status_rd);
endmodule

// [aur_pkg.sv]
package aur_pkg;
  localparam logic [4:0] MMD_AN = 5'h07;
  localparam logic [15:0] REG_CTRL = 16'h0200;
  localparam logic [15:0] REG_STATUS = 16'h0201;
  localparam logic [15:0] REG_ADV_L = 16'h0202;
  localparam logic [15:0] REG_ADV_M = 16'h0203;
  localparam logic [15:0] CTRL_RESET = 16'h1000;
  localparam logic [15:0] STATUS_RESET = 16'h0008;
  localparam logic [15:0] ADV_L_RESET = 16'h0001;
  localparam logic [15:0] ADV_M_RESET = 16'h4000;
  localparam int CTRL_EN_BIT = 12;
  localparam int CTRL_RESTART_BIT = 9;
  localparam int ST_PAGE_BIT = 6;
  localparam int ST_DONE_BIT = 5;
  localparam int ST_FAULT_BIT = 4;
  localparam int ST_ABLE_BIT = 3;
  localparam int ST_LINK_BIT = 2;
  localparam int ADV_NP_BIT = 15;
  localparam int ADV_ACK_BIT = 14;
  localparam int ADV_RF_BIT = 13;
  localparam int ADV_FMS_BIT = 12;
  localparam int ADV_PAUSE_LSB = 10;
  localparam int ADV_M_B10L_BIT = 14;
  localparam int ADV_M_MST_BIT = 4;
  localparam logic [4:0] SELECTOR_VALUE = 5'h01;
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ_INC = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  localparam logic [4:0] CNT_HDR_LAST = 5'h0D;
  localparam logic [4:0] CNT_TA_FIRST = 5'h0E;
  localparam logic [4:0] CNT_TA_LAST = 5'h0F;
  localparam logic [4:0] CNT_DATA_LAST = 5'h1F;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  typedef enum logic [1:0] {
    AUR_FR_PRE = 2'b00,
    AUR_FR_HDR = 2'b01,
    AUR_FR_TURN = 2'b11,
    AUR_FR_DATA = 2'b10
  } aur_frame_e;
endpackage

// [aur_sync.sv]
`timescale 1ns/1ps
module aur_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

// [aur_latch_bit.sv]
`timescale 1ns/1ps
module aur_latch_bit #(
  parameter bit LATCH_LOW = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cond,
  input wire logic rd_clr,
  output logic q
);
  // A clearing read reloads from the live condition, so an event in the
  // same cycle as the read is kept
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= 1'b0;
    end else if (rd_clr) begin
      q <= cond;
    end else if (LATCH_LOW) begin
      q <= q & cond;
    end else begin
      q <= q | cond;
    end
  end
endmodule

// [aur_mdio_host.sv]
`timescale 1ns/1ps
module aur_mdio_host (
  input wire logic mclk,
  input wire logic line,
  output logic mdc,
  output logic drv,
  output logic drv_en
);
  // Clock pin stands still low between frames; no free-running clock
  initial begin
    mdc = 1'h0;
    drv = 1'h1;
    drv_en = 1'h0;
  end

  // One bit every 12 core cycles keeps the pin well below its limit
  task automatic put_bit(input logic b, input logic en, output logic s);
    @(negedge mclk);
    drv = b;
    drv_en = en;
    repeat (5) @(negedge mclk);
    mdc = 1'h1;
    s = line;
    repeat (6) @(negedge mclk);
    mdc = 1'h0;
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] prt,
    input logic [4:0] dev, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] w;
    logic s;
    w = {2'h0, op, prt, dev, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      put_bit(1'h1, 1'h1, s);
    end
    for (int i = 31; i >= 0; i--) begin
      // Reads leave turnaround and data to the device
      put_bit(w[i], !(op[1] && i < 18), s);
      if (op[1] && i < 16) begin
        rd[i] = s;
      end
    end
    drv_en = 1'h0;
  endtask
endmodule

// [tb_aur_regs.sv]
`timescale 1ns/1ps
module tb_aur_regs;
  localparam logic [4:0] PORT = 5'h05;
  logic mclk, rst, mdc, h_o, h_en, mdio_w, mdio_out, mdio_oe_n;
  logic page_stored, base_page_stored, partner_fault, link_ok;
  logic negotiation_finished, local_acknowledge, restart_begun;
  logic negotiation_enable, negotiation_restart, local_next_page_request;
  logic local_fault_advertised, role_forced_select, role_master_select;
  logic ten_t1l_ability, role_strap;
  logic [1:0] pause_capability;
  logic [15:0] rv;
  int num_errors = 0;
  int total_checks = 0;

  // Pull-up on the shared data line: high when nobody drives low
  assign mdio_w = (mdio_oe_n ? 1'h1 : mdio_out) & (h_en ? h_o : 1'h1);

  aur_mdio_host host (.mclk(mclk), .line(mdio_w), .mdc(mdc), .drv(h_o),
    .drv_en(h_en));

  aur_regs uut (.mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_w),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(PORT),
    .role_strap(role_strap), .page_stored(page_stored),
    .base_page_stored(base_page_stored), .partner_fault(partner_fault),
    .negotiation_finished(negotiation_finished), .link_ok(link_ok),
    .local_acknowledge(local_acknowledge), .restart_begun(restart_begun),
    .negotiation_enable(negotiation_enable),
    .negotiation_restart(negotiation_restart),
    .local_next_page_request(local_next_page_request),
    .local_fault_advertised(local_fault_advertised),
    .role_forced_select(role_forced_select),
    .pause_capability(pause_capability),
    .role_master_select(role_master_select),
    .ten_t1l_ability(ten_t1l_ability));

  initial mclk = 1'h0;
  always #25 mclk = ~mclk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    host.frame(aur_pkg::OP_ADDR, PORT, aur_pkg::MMD_AN, a, rv);
    host.frame(aur_pkg::OP_WRITE, PORT, aur_pkg::MMD_AN, d, rv);
  endtask

  task automatic rchk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    host.frame(aur_pkg::OP_ADDR, PORT, aur_pkg::MMD_AN, a, d);
    host.frame(aur_pkg::OP_READ, PORT, aur_pkg::MMD_AN, 16'h0000, d);
    chk(d, e);
  endtask

  function automatic logic [15:0] st(input logic p, d, f, l);
    return {9'h000, p, d, f, 1'h1, l, 2'h0};
  endfunction

  task automatic pages(input logic base);
    @(negedge mclk);
    page_stored = 1'h1;
    base_page_stored = base;
    @(negedge mclk);
    page_stored = 1'h0;
    base_page_stored = 1'h0;
  endtask

  task automatic t_reset;
    chk(negotiation_enable, 16'h0001);
    chk(negotiation_restart, 16'h0000);
    // Strap is held high from reset, so the role bit must come up master
    chk(role_master_select, 16'h0001);
    rchk(aur_pkg::REG_ADV_M, 16'h4010);
    rchk(aur_pkg::REG_STATUS, aur_pkg::STATUS_RESET);
    rchk(aur_pkg::REG_ADV_L, aur_pkg::ADV_L_RESET);
    rchk(16'h0210, 16'h0000);
    // Another device address must leave the line to the pull-up
    host.frame(aur_pkg::OP_READ, PORT, 5'h03, 16'h0000, rv);
    chk(rv, 16'hFFFF);
    $display("test reset done");
  endtask

  task automatic t_adv;
    @(negedge mclk);
    local_acknowledge = 1'h1;
    wr(aur_pkg::REG_ADV_L, 16'hFFFF);
    rchk(aur_pkg::REG_ADV_L, 16'hFC01);
    chk({local_next_page_request, local_fault_advertised,
      role_forced_select, pause_capability}, 16'h001F);
    wr(aur_pkg::REG_ADV_M, 16'h0000);
    chk({ten_t1l_ability, role_master_select}, 16'h0000);
    rchk(aur_pkg::REG_ADV_M, 16'h0000);
    @(negedge mclk);
    local_acknowledge = 1'h0;
    wr(aur_pkg::REG_ADV_L, 16'h0000);
    rchk(aur_pkg::REG_ADV_L, 16'h0001);
    chk({local_next_page_request, local_fault_advertised,
      role_forced_select, pause_capability}, 16'h0000);
    $display("test advert done");
  endtask

  // Read-increment steps the pointer after each frame; plain read holds it
  task automatic t_rdinc;
    host.frame(aur_pkg::OP_ADDR, PORT, aur_pkg::MMD_AN, aur_pkg::REG_CTRL,
      rv);
    host.frame(aur_pkg::OP_READ_INC, PORT, aur_pkg::MMD_AN, 16'h0000, rv);
    chk(rv, aur_pkg::CTRL_RESET);
    host.frame(aur_pkg::OP_READ_INC, PORT, aur_pkg::MMD_AN, 16'h0000, rv);
    chk(rv, aur_pkg::STATUS_RESET);
    host.frame(aur_pkg::OP_READ, PORT, aur_pkg::MMD_AN, 16'h0000, rv);
    chk(rv, aur_pkg::ADV_L_RESET);
    host.frame(aur_pkg::OP_READ, PORT, aur_pkg::MMD_AN, 16'h0000, rv);
    chk(rv, aur_pkg::ADV_L_RESET);
    $display("test read increment done");
  endtask

  task automatic t_latch;
    @(negedge mclk);
    link_ok = 1'h1;
    rchk(aur_pkg::REG_STATUS, st(0, 0, 0, 0));
    rchk(aur_pkg::REG_STATUS, st(0, 0, 0, 1));
    @(negedge mclk);
    link_ok = 1'h0;
    repeat (2) @(negedge mclk);
    link_ok = 1'h1;
    rchk(aur_pkg::REG_STATUS, st(0, 0, 0, 0));
    rchk(aur_pkg::REG_STATUS, st(0, 0, 0, 1));
    pages(1'h0);
    rchk(aur_pkg::REG_STATUS, st(1, 0, 0, 1));
    rchk(aur_pkg::REG_STATUS, st(0, 0, 0, 1));
    @(negedge mclk);
    negotiation_finished = 1'h1;
    // Finished and link up, but no partner base page yet
    rchk(aur_pkg::REG_STATUS, st(0, 0, 0, 1));
    partner_fault = 1'h1;
    pages(1'h1);
    partner_fault = 1'h0;
    rchk(aur_pkg::REG_STATUS, st(1, 1, 1, 1));
    rchk(aur_pkg::REG_STATUS, st(0, 1, 0, 1));
    wr(aur_pkg::REG_CTRL, 16'h0000);
    chk(negotiation_enable, 16'h0000);
    rchk(aur_pkg::REG_STATUS, st(0, 0, 0, 1));
    wr(aur_pkg::REG_CTRL, 16'h1000);
    rchk(aur_pkg::REG_STATUS, st(0, 0, 0, 1));
    $display("test latch done");
  endtask

  task automatic t_restart;
    wr(aur_pkg::REG_CTRL, 16'h1200);
    chk(negotiation_restart, 16'h0001);
    rchk(aur_pkg::REG_CTRL, 16'h1200);
    pages(1'h1);
    rchk(aur_pkg::REG_STATUS, st(1, 1, 0, 1));
    @(negedge mclk);
    restart_begun = 1'h1;
    @(negedge mclk);
    restart_begun = 1'h0;
    chk(negotiation_restart, 16'h0000);
    rchk(aur_pkg::REG_CTRL, 16'h1000);
    rchk(aur_pkg::REG_STATUS, st(0, 0, 0, 1));
    $display("test restart done");
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst = 1'h1;
    role_strap = 1'h1;
    page_stored = 1'h0;
    base_page_stored = 1'h0;
    partner_fault = 1'h0;
    negotiation_finished = 1'h0;
    link_ok = 1'h0;
    local_acknowledge = 1'h0;
    restart_begun = 1'h0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst = 1'h0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_adv();
    t_rdinc();
    t_latch();
    t_restart();
    report_and_stop();
  end

  // About 60 frames of 768 core cycles each are expected
  initial begin
    #4000000;
    num_errors++;
    report_and_stop();
  end
endmodule
